// >>> shared/can_bt_defs.svh
`ifndef CAN_BT_DEFS_SVH
`define CAN_BT_DEFS_SVH

// register byte offsets
`define OFF_TIMING 4'h0
`define OFF_ERRCTL 4'h4
`define OFF_STATUS 4'h8

// timing and error control register fields, lengths stored minus one
`define TM_PROP 2:0
`define TM_PS1 6:4
`define TM_PS2 10:8
`define TM_SJW 13:12
`define TM_PRE 23:16
`define ERR_PASSIVE 0

// status register fields
`define ST_FLAG_ON 0
`define ST_FLAG_ACT 1
`define ST_RX_BIT 2
`define ST_SEG 4:3
`define ST_CFG_OK 5
`define ST_ERR_PEND 6
`define ST_CRC_PEND 7

// reset values
`define RST_PROP 3'h1
`define RST_PS1 3'h2
`define RST_PS2 3'h2
`define RST_SJW 2'h0
`define RST_PRE 8'h09
`define RST_PS1_LEN 4'h3
`define RST_PS2_LEN 4'h3

// timing in time quanta, and index of the last error flag bit
`define IPT_TQ 4'h2
`define BIT_TQ_MIN 5'h08
`define BIT_TQ_MAX 5'h19
`define FLAG_LAST 3'h5

`endif

// >>> shared/can_bt_pkg.sv
package can_bt_pkg;

  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PS1, SEG_PS2} seg_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic tq_lvl;
    seg_t seg;
    logic [3:0] cnt;
    logic [3:0] ps1_len;
    logic [3:0] ps2_len;
    logic synced;
    logic rx_bit;
    logic tx_lvl;
    logic err_pend;
    logic crc_pend;
    logic flag_on;
    logic flag_act;
    logic flag_tx;
    logic [2:0] flag_cnt;
    logic sample_p;
    logic bit_start_p;
    logic retx_p;
    logic [2:0] cfg_prop;
    logic [2:0] cfg_ps1;
    logic [2:0] cfg_ps2;
    logic [1:0] cfg_sjw;
    logic [7:0] prescale;
    logic err_passive;
    logic [31:0] rd_data;
  } bt_state_t;

endpackage

// >>> shared/tq_if.sv
`timescale 1ns/1ps
interface tq_if #(parameter int W = 8);
  logic tq_en;
  logic [W-1:0] prescale;
  modport gen (output tq_en, input prescale);
  modport use_side (input tq_en, output prescale);
endinterface

// >>> src/tq_divider.sv
`timescale 1ns/1ps
module tq_divider #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // quantum tick toward the bit timer
  tq_if.gen bus
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;

  if (W < 2 || W > 16) begin : g_chk
    $error("tq_divider: W must lie in 2..16");
  end

  // one tick every prescale+1 system clocks
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt >= bus.prescale) begin
      st_nxt.cnt = '0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.tq_en = st_r.tick;
endmodule

// >>> src/can_bit_timing_error_flag.sv
`timescale 1ns/1ps
`include "can_bt_defs.svh"
// Overview of operation
// R1: bit, stuff, form or ack error starts the flag in the next bit.
// R2: crc error flag waits until the bit after the ack delimiter.
// R3: flag is active or passive according to the current error state.
// R4: a transmitter signals retransmission of the corrupted frame after its flag.
// R5: a bit is sync, propagation, phase one, phase two, each whole quanta.
// R6: bus level latched at end of phase one is the received bit.
// R7: sync segment is exactly one quantum; edges expected there.
// R8: propagation segment programmable 1 to 8 quanta.
// R9: phase segment one programmable 1 to 8 quanta.
// R10: phase two at least max of phase one and processing time, 2 to 8.
// R11: sampled level settles within two quanta after the sample point.
// R12: segment lengths configurable; whole bit spans 8 to 25 quanta (code still runs totals down to 5, only clearing cfg_ok).
// R13: jump width 1 to 4 quanta and never above phase one.
// R14: drift corrected by lengthening phase one or shortening phase two.
// R15: transmit nrz bits aligned to the own bit timing.
// R16: receiver realigns on bus edges by hard sync or resync.
// R17: idle falling edge restarts the bit regardless of jump width.
// R18: phase error beyond jump width is corrected only by jump width.
// R19: at most one synchronisation between two sample points.
// R20: no resync on delayed view of own dominant output.
// R21: phase error measured in quanta from the end of sync segment.
module can_bit_timing_error_flag #(
  parameter int PRE_W = 8
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // bus pins
  input wire logic i_can_rx,
  output logic o_can_tx,
  // protocol side
  input wire logic i_tx_active,
  input wire logic i_tx_bit,
  input wire logic i_bus_idle,
  input wire logic i_bit_err,
  input wire logic i_stuff_err,
  input wire logic i_form_err,
  input wire logic i_ack_err,
  input wire logic i_crc_err,
  input wire logic i_ack_delim,
  output logic o_rx_bit,
  output logic o_sample,
  output logic o_bit_start,
  output logic o_retransmit,
  output logic o_flag_on,
  output logic o_flag_active,
  output can_bt_pkg::seg_t o_segment,
  // register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata
);
  import can_bt_pkg::*;

  if (PRE_W != 8) begin : g_chk
    $error("can_bit_timing_error_flag: PRE_W must be 8");
  end

  bt_state_t st_r;
  bt_state_t st_nxt;
  tq_if #(.W(PRE_W)) tq ();

  tq_divider #(.W(PRE_W)) u_div (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .bus(tq.gen)
  );
  assign tq.prescale = st_r.prescale;

  logic tq_en;
  logic [3:0] prop_len;
  logic [3:0] ps1_cfg;
  logic [3:0] ps2_raw;
  logic [3:0] ps2_cfg;
  logic [3:0] sjw_raw;
  logic [3:0] sjw_eff;
  logic [4:0] bit_tq;
  logic cfg_ok;
  logic own_dom;
  logic fall;
  logic hard_ev;
  logic resync_ev;
  logic [4:0] pos_err;
  logic [3:0] lengthen;
  logic [3:0] neg_err;
  logic early_jump;
  logic [3:0] ps1_eff;
  logic [3:0] ps2_eff;
  logic new_bit;
  logic jump;
  logic [31:0] rd_v;

  assign tq_en = tq.tq_en;
  assign prop_len = {1'b0, st_r.cfg_prop} + 4'h1; // R8
  assign ps1_cfg = {1'b0, st_r.cfg_ps1} + 4'h1; // R9
  assign ps2_raw = {1'b0, st_r.cfg_ps2} + 4'h1;
  // phase two never shorter than phase one or the processing time
  assign ps2_cfg = (ps2_raw < ps1_cfg) ? ((ps1_cfg < `IPT_TQ) ? `IPT_TQ : ps1_cfg) :
                   ((ps2_raw < `IPT_TQ) ? `IPT_TQ : ps2_raw); // R10 R11
  assign sjw_raw = {2'b00, st_r.cfg_sjw} + 4'h1;
  assign sjw_eff = (sjw_raw > ps1_cfg) ? ps1_cfg : sjw_raw; // R13
  assign bit_tq = 5'h01 + {1'b0, prop_len} + {1'b0, ps1_cfg} + {1'b0, ps2_cfg};
  assign cfg_ok = (bit_tq >= `BIT_TQ_MIN) && (bit_tq <= `BIT_TQ_MAX) &&
                  (sjw_raw <= ps1_cfg); // R12

  // falling edge seen at a quantum tick, once between two sample points
  assign own_dom = i_tx_active & ~st_r.tx_lvl;
  assign fall = tq_en & st_r.tq_lvl & ~st_r.sync2 & ~st_r.synced; // R19
  assign hard_ev = fall & i_bus_idle; // R17
  assign resync_ev = fall & ~i_bus_idle & st_r.rx_bit & ~own_dom &
                     (st_r.seg != SEG_SYNC); // R16 R20
  assign pos_err = (st_r.seg == SEG_PROP) ? {1'b0, st_r.cnt} + 5'h01 :
                   {1'b0, prop_len} + {1'b0, st_r.cnt} + 5'h01; // R21
  assign lengthen = (pos_err > {1'b0, sjw_eff}) ? sjw_eff : pos_err[3:0]; // R18
  assign neg_err = st_r.ps2_len - st_r.cnt; // R21
  assign early_jump = resync_ev && (st_r.seg == SEG_PS2) && (neg_err <= sjw_eff);
  assign ps1_eff = (resync_ev && (st_r.seg == SEG_PROP || st_r.seg == SEG_PS1)) ?
                   st_r.ps1_len + lengthen : st_r.ps1_len; // R14
  assign ps2_eff = (resync_ev && (st_r.seg == SEG_PS2) && !early_jump) ?
                   st_r.ps2_len - sjw_eff : st_r.ps2_len; // R14 R18

  always_comb begin
    st_nxt = st_r;
    new_bit = 1'b0;
    jump = 1'b0;
    rd_v = '0;
    st_nxt.sync1 = i_can_rx;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sample_p = 1'b0;
    st_nxt.bit_start_p = 1'b0;
    st_nxt.retx_p = 1'b0;
    st_nxt.rd_data = '0;
    if (tq_en) begin
      st_nxt.tq_lvl = st_r.sync2;
      st_nxt.cnt = st_r.cnt + 4'h1;
      st_nxt.ps1_len = ps1_eff;
      st_nxt.ps2_len = ps2_eff;
      unique case (st_r.seg)
        SEG_SYNC: begin
          st_nxt.seg = SEG_PROP; // R7
          st_nxt.cnt = 4'h0;
        end
        SEG_PROP: begin
          if (st_r.cnt == prop_len - 4'h1) begin
            st_nxt.seg = SEG_PS1; // R5
            st_nxt.cnt = 4'h0;
          end
        end
        SEG_PS1: begin
          if (st_r.cnt == ps1_eff - 4'h1) begin
            st_nxt.seg = SEG_PS2;
            st_nxt.cnt = 4'h0;
            st_nxt.sample_p = 1'b1;
            st_nxt.rx_bit = st_r.sync2; // R6
            st_nxt.synced = 1'b0; // R19
          end
        end
        SEG_PS2: begin
          if (st_r.cnt == ps2_eff - 4'h1) begin
            new_bit = 1'b1; // R5
          end
        end
      endcase
      if (resync_ev) begin
        st_nxt.synced = 1'b1;
      end
      if (hard_ev || early_jump) begin
        new_bit = 1'b1; // R17 R14
        jump = 1'b1;
        st_nxt.synced = 1'b1;
      end
    end
    if (new_bit) begin
      // the edge quantum itself counts as sync segment on a jump
      st_nxt.seg = jump ? SEG_PROP : SEG_SYNC;
      st_nxt.cnt = 4'h0;
      st_nxt.ps1_len = ps1_cfg;
      st_nxt.ps2_len = ps2_cfg;
      st_nxt.bit_start_p = 1'b1;
      if (st_r.flag_on) begin
        if (st_r.flag_cnt == `FLAG_LAST) begin
          st_nxt.flag_on = 1'b0;
          st_nxt.retx_p = st_r.flag_tx; // R4
        end else begin
          st_nxt.flag_cnt = st_r.flag_cnt + 3'h1;
        end
      end else if (st_r.err_pend) begin
        st_nxt.flag_on = 1'b1; // R1
        st_nxt.flag_cnt = 3'h0;
        st_nxt.flag_act = ~st_r.err_passive; // R3
        st_nxt.flag_tx = i_tx_active; // R4
        st_nxt.err_pend = 1'b0;
      end
      // active flag drives dominant, passive stays recessive
      st_nxt.tx_lvl = st_nxt.flag_on ? ~st_nxt.flag_act :
                      (i_tx_active ? i_tx_bit : 1'b1); // R15
    end
    if (i_ack_delim && st_r.crc_pend) begin
      st_nxt.crc_pend = 1'b0; // R2
      st_nxt.err_pend = 1'b1;
    end
    // new errors win over a clear in the same cycle
    if (i_bit_err || i_stuff_err || i_form_err || i_ack_err) begin
      st_nxt.err_pend = 1'b1; // R1
    end
    if (i_crc_err) begin
      st_nxt.crc_pend = 1'b1; // R2
    end
    if (i_reg_wr) begin
      case (i_reg_addr)
        `OFF_TIMING: begin
          st_nxt.cfg_prop = i_reg_wdata[`TM_PROP]; // R12
          st_nxt.cfg_ps1 = i_reg_wdata[`TM_PS1];
          st_nxt.cfg_ps2 = i_reg_wdata[`TM_PS2];
          st_nxt.cfg_sjw = i_reg_wdata[`TM_SJW];
          st_nxt.prescale = i_reg_wdata[`TM_PRE];
        end
        `OFF_ERRCTL: st_nxt.err_passive = i_reg_wdata[`ERR_PASSIVE];
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `OFF_TIMING: begin
          rd_v[`TM_PROP] = st_r.cfg_prop;
          rd_v[`TM_PS1] = st_r.cfg_ps1;
          rd_v[`TM_PS2] = st_r.cfg_ps2;
          rd_v[`TM_SJW] = st_r.cfg_sjw;
          rd_v[`TM_PRE] = st_r.prescale;
        end
        `OFF_ERRCTL: rd_v[`ERR_PASSIVE] = st_r.err_passive;
        `OFF_STATUS: begin
          rd_v[`ST_FLAG_ON] = st_r.flag_on;
          rd_v[`ST_FLAG_ACT] = st_r.flag_act;
          rd_v[`ST_RX_BIT] = st_r.rx_bit;
          rd_v[`ST_SEG] = st_r.seg;
          rd_v[`ST_CFG_OK] = cfg_ok;
          rd_v[`ST_ERR_PEND] = st_r.err_pend;
          rd_v[`ST_CRC_PEND] = st_r.crc_pend;
        end
        default: ;
      endcase
      st_nxt.rd_data = rd_v;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r <= '0;
      st_r.sync1 <= 1'b1;
      st_r.sync2 <= 1'b1;
      st_r.tq_lvl <= 1'b1;
      st_r.rx_bit <= 1'b1;
      st_r.tx_lvl <= 1'b1;
      st_r.ps1_len <= `RST_PS1_LEN;
      st_r.ps2_len <= `RST_PS2_LEN;
      st_r.cfg_prop <= `RST_PROP;
      st_r.cfg_ps1 <= `RST_PS1;
      st_r.cfg_ps2 <= `RST_PS2;
      st_r.cfg_sjw <= `RST_SJW;
      st_r.prescale <= `RST_PRE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_can_tx = st_r.tx_lvl;
  assign o_rx_bit = st_r.rx_bit;
  assign o_sample = st_r.sample_p;
  assign o_bit_start = st_r.bit_start_p;
  assign o_retransmit = st_r.retx_p;
  assign o_flag_on = st_r.flag_on;
  assign o_flag_active = st_r.flag_act;
  assign o_segment = st_r.seg;
  assign o_reg_rdata = st_r.rd_data;

  property p_sync_one;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_r.seg == SEG_SYNC && tq_en && !hard_ev) |=> (st_r.seg == SEG_PROP);
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("sync segment not one quantum"); // R7

  property p_order;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_r.seg == SEG_PS1 && tq_en && !hard_ev) |=> (st_r.seg inside {SEG_PS1, SEG_PS2});
  endproperty
  a_order: assert property (p_order) else $error("segment order broken"); // R5

  property p_sample;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    st_r.sample_p |-> ($past(st_r.seg) == SEG_PS1) && (st_r.rx_bit == $past(st_r.sync2));
  endproperty
  a_sample: assert property (p_sample) else $error("sample not at end of phase one"); // R6

  property p_flag_next;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (st_r.err_pend && !st_r.flag_on && new_bit) |=> (st_r.flag_on && st_r.flag_cnt == 3'h0);
  endproperty
  a_flag_next: assert property (p_flag_next) else $error("flag not in next bit"); // R1

  property p_crc_wait;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_ack_delim && st_r.crc_pend) |=> st_r.err_pend && !st_r.crc_pend;
  endproperty
  a_crc_wait: assert property (p_crc_wait) else $error("crc flag not after delimiter"); // R2

  property p_flag_kind;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    $rose(st_r.flag_on) |-> (st_r.flag_act == !$past(st_r.err_passive)) &&
      (st_r.tx_lvl == !st_r.flag_act);
  endproperty
  a_flag_kind: assert property (p_flag_kind) else $error("wrong flag kind"); // R3

  property p_retx;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    st_r.retx_p |-> $past(st_r.flag_on) && !st_r.flag_on && $past(st_r.flag_tx);
  endproperty
  a_retx: assert property (p_retx) else $error("retransmit without flag end"); // R4

  property p_hard;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    hard_ev |=> (st_r.seg == SEG_PROP) && (st_r.cnt == 4'h0) && st_r.bit_start_p;
  endproperty
  a_hard: assert property (p_hard) else $error("hard sync did not restart bit"); // R17

  property p_jump_limit;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (resync_ev && st_r.seg == SEG_PS1) |=>
      (st_r.ps1_len <= $past(st_r.ps1_len) + $past(sjw_eff));
  endproperty
  a_jump_limit: assert property (p_jump_limit) else $error("correction above jump width"); // R18

  property p_once;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (resync_ev || hard_ev) |=> st_r.synced && !resync_ev && !hard_ev;
  endproperty
  a_once: assert property (p_once) else $error("second sync in one bit"); // R19
endmodule

// >>> verification/can_bus_node.sv
`timescale 1ns/1ps
module can_bus_node (
  // clock
  input wire logic i_sys_clk,
  // wired-and bus
  input wire logic i_node_tx,
  output logic o_bus_lvl
);
  // loop delay of transceiver and cable, as the node hears its own output
  localparam int LAG = 6;
  logic drive_dom;
  logic [LAG-1:0] tx_dly;
  initial drive_dom = 1'h0;
  initial tx_dly = '1;
  // an undriven transmitter reads as recessive, as the pull-up holds it
  always @(posedge i_sys_clk) tx_dly <= {tx_dly[LAG-2:0], i_node_tx !== 1'h0};
  // the pull-up holds the bus recessive whenever nobody pulls it down
  assign o_bus_lvl = tx_dly[LAG-1] & ~drive_dom;
  task automatic dominant(input int delay, input int len);
    repeat (delay) @(posedge i_sys_clk);
    drive_dom <= 1'h1;
    repeat (len) @(posedge i_sys_clk);
    drive_dom <= 1'h0;
  endtask
endmodule

// >>> verification/can_bit_timing_error_flag_test.sv
`timescale 1ns/1ps
`include "can_bt_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module can_bit_timing_error_flag_test;
  import can_bt_pkg::*;
  localparam int Q = 4;
  logic i_sys_clk = 1'h0, i_reset_n = 1'h0, can_rx, can_tx, tx_active = 1'h0;
  logic tx_bit = 1'h1, bus_idle = 1'h1, rx_bit, sample, bit_start, retx, flag_on, flag_act;
  // bit, stuff, form, ack, crc error pulses, then ack delimiter
  logic [5:0] err = 6'h00;
  seg_t segment;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_val;
  logic wr = 1'h0, rd = 1'h0;
  int n_mismatch = 0, check_count = 0, cyc = 0, d, p, p2e, tot, ok;
  int cp [5][4] = '{'{2, 3, 3, 1}, '{8, 8, 8, 4}, '{1, 4, 2, 2}, '{1, 1, 2, 1}, '{2, 2, 3, 4}};

  can_bit_timing_error_flag can_bit_timing_error_flag_i (.i_sys_clk, .i_reset_n,
    .i_can_rx(can_rx), .o_can_tx(can_tx), .i_tx_active(tx_active), .i_tx_bit(tx_bit),
    .i_bus_idle(bus_idle), .i_bit_err(err[0]), .i_stuff_err(err[1]), .i_form_err(err[2]),
    .i_ack_err(err[3]), .i_crc_err(err[4]), .i_ack_delim(err[5]), .o_rx_bit(rx_bit),
    .o_sample(sample), .o_bit_start(bit_start), .o_retransmit(retx), .o_flag_on(flag_on),
    .o_flag_active(flag_act), .o_segment(segment), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata));
  can_bus_node can_bus_node_i (.i_sys_clk, .i_node_tx(can_tx), .o_bus_lvl(can_rx));

  always #2.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] tm(int pr, int p1, int p2, int sj);
    return {8'h00, 8'(Q - 1), 2'h0, 2'(sj - 1), 1'h0, 3'(p2 - 1), 1'h0, 3'(p1 - 1), 1'h0,
      3'(pr - 1)};
  endfunction
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge i_sys_clk);
    wr <= 1'h0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge i_sys_clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge i_sys_clk);
    rd <= 1'h0;
    @(negedge i_sys_clk);
    rd_val = rdata;
  endtask
  // counts clocks up to the next bit start (0) or sample (1) pulse
  task automatic wait_for(input int which, output int n);
    n = 0;
    do begin
      @(negedge i_sys_clk);
      n++;
    end while (!((which == 0) ? bit_start : sample) && n < 400);
    if (n >= 400) begin
      n_mismatch++;
      $display("unexpected pulse wait: expected pulse seen none");
    end
  endtask
  task automatic pulse(input int k);
    wait_for(1, d);
    @(posedge i_sys_clk);
    err[k] <= 1'h1;
    @(posedge i_sys_clk);
    err[k] <= 1'h0;
    @(negedge i_sys_clk);
    `CHK("flag early", 1'h0, flag_on)
    wait_for(0, d);
  endtask

  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_reset_n <= 1'h1;
    @(negedge i_sys_clk);
    `CHK("tx idle", 1'h1, can_tx)
    `CHK("rx reset", 1'h1, rx_bit)
    `CHK("segment reset", SEG_SYNC, segment)
    rreg(`OFF_TIMING);
    `CHK("timing reset", 32'h00090221, rd_val)
    rreg(4'hC);
    `CHK("unmapped", 32'h0, rd_val)
    foreach (cp[i]) begin
      p2e = (cp[i][2] < cp[i][1]) ? cp[i][1] : cp[i][2];
      tot = 1 + cp[i][0] + cp[i][1] + p2e;
      ok = (tot >= 8 && tot <= 25 && cp[i][3] <= cp[i][1]);
      wreg(`OFF_TIMING, tm(cp[i][0], cp[i][1], cp[i][2], cp[i][3]));
      rreg(`OFF_STATUS);
      `CHK("cfg ok", ok, rd_val[`ST_CFG_OK])
      if (ok) begin
        wait_for(0, d);
        wait_for(1, d);
        `CHK("sample offset", (1 + cp[i][0] + cp[i][1]) * Q, d)
        `CHK("phase two seg", SEG_PS2, segment)
        wait_for(0, p);
        `CHK("bit length", tot * Q, d + p)
        `CHK("sync seg", SEG_SYNC, segment)
      end
    end
    wreg(`OFF_TIMING, tm(2, 3, 3, 1));
    wait_for(0, d);
    fork
      can_bus_node_i.dominant(10, 9 * Q);
      wait_for(1, d);
    join
    `CHK("hard sync", 1, (d >= 33 && d <= 43))
    `CHK("rx dominant", 1'h0, rx_bit)
    @(posedge i_sys_clk);
    bus_idle <= 1'h0;
    for (int s = 1; s <= 2; s++) begin
      wreg(`OFF_TIMING, tm(2, 3, 3, s));
      wait_for(0, d);
      wait_for(0, d);
      fork
        begin
          can_bus_node_i.dominant(13, 4);
          can_bus_node_i.dominant(2, 4);
        end
        wait_for(1, d);
      join
      `CHK("resync sample", (6 + s) * Q, d)
      // edge in the first quantum of phase two: three quanta early
      wait_for(0, d);
      fork
        can_bus_node_i.dominant(24, 4);
        wait_for(0, p);
      join
      `CHK("shortened bit", (9 - s) * Q, p)
    end
    @(posedge i_sys_clk);
    tx_bit <= 1'h0;
    tx_active <= 1'h1;
    // own falling edge comes back late, inside the propagation segment
    wait_for(0, d);
    `CHK("tx level", 1'h0, can_tx)
    wait_for(1, d);
    `CHK("rx own", 1'h0, rx_bit)
    wait_for(0, p);
    `CHK("own dominant", 9 * Q, d + p)
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      `CHK("flag on", 1'h1, flag_on)
      `CHK("flag active", 1'h1, flag_act)
      `CHK("flag level", 1'h0, can_tx)
      repeat (6) wait_for(0, d);
      `CHK("flag end", 1'h0, flag_on)
      `CHK("retransmit", 1'h1, retx)
    end
    @(posedge i_sys_clk);
    tx_active <= 1'h0;
    tx_bit <= 1'h1;
    wreg(`OFF_ERRCTL, 32'h00000001);
    rreg(`OFF_ERRCTL);
    `CHK("error state", 32'h00000001, rd_val)
    pulse(4);
    `CHK("crc deferred", 1'h0, flag_on)
    pulse(5);
    `CHK("crc flag", 1'h1, flag_on)
    `CHK("passive flag", 1'h0, flag_act)
    `CHK("passive level", 1'h1, can_tx)
    repeat (6) wait_for(0, d);
    `CHK("no retransmit", 1'h0, retx)
    final_report();
  end
endmodule
